// ---- rtl/vpg_pkg.sv ----
package vpg_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [11:0] VPG_OFF_DIR_HI = 12'ha38;
  localparam logic [11:0] VPG_OFF_AVAIL = 12'ha3c;
  localparam logic [11:0] VPG_OFF_DEBOUNCE = 12'ha40;
  localparam logic [11:0] VPG_OFF_IN_DATA = 12'ha44;
  localparam logic [11:0] VPG_OFF_OUT_DATA = 12'ha48;
  // ----------------------------------------
  // field positions in the line 10/11 direction register
  // ----------------------------------------
  localparam int VPG_L10_ROUTE_LSB = 0;
  localparam int VPG_L10_DIR_BIT = 2;
  localparam int VPG_L11_ROUTE_LSB = 3;
  localparam int VPG_L11_DIR_BIT = 5;
  localparam int VPG_AVAIL_W = 4;
  localparam int VPG_LINES = 12;
  localparam int VPG_LO_LINES = 10;
  // ----------------------------------------
  // routing codes
  // ----------------------------------------
  localparam logic [1:0] VPG_ROUTE_DATA = 2'h0;
  localparam logic [1:0] VPG_ROUTE_IRQ = 2'h1;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [1:0] VPG_RST_ROUTE = 2'h0;
  localparam logic VPG_RST_DIR = 1'b0;
  localparam logic [3:0] VPG_RST_AVAIL = 4'h0;
  localparam logic [11:0] VPG_RST_DEBOUNCE = 12'h000;
  localparam logic [11:0] VPG_RST_OUT_DATA = 12'h000;
  // ----------------------------------------
  // de-bounce timing
  // ----------------------------------------
  localparam int VPG_CLK_PERIOD_PS = 5000;
  localparam int VPG_DEBOUNCE_TIME_US_X10 = 13000;
  localparam int VPG_DEBOUNCE_CYCLES =
    (VPG_DEBOUNCE_TIME_US_X10 * 100000) / VPG_CLK_PERIOD_PS;
  localparam int VPG_DB_CNT_W = 19;
endpackage

// ---- rtl/vpg_port_good.sv ----
`timescale 1ns/100ps
module vpg_port_good
  import vpg_pkg::*;
#(
  parameter int DB_CYCLES = VPG_DEBOUNCE_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic pwr_rst,
  input wire logic cfg_valid,
  input wire logic cfg_write,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [3:0] cfg_be,
  output logic [31:0] cfg_rdata_q,
  output logic cfg_ack_q,
  input wire logic load_valid,
  input wire logic [11:0] load_addr,
  input wire logic [31:0] load_data,
  input wire logic [9:0] lo_dir,
  input wire logic [19:0] lo_route,
  input wire logic [11:0] assign_mask,
  input wire logic [11:0] other_claim,
  input wire logic [11:0] port_good_func,
  input wire logic [11:0] port_good_pin_in,
  output logic [11:0] port_good_pin_out_q,
  output logic [11:0] port_good_pin_oe_q,
  output logic gen_irq_q
);
  // ----------------------------------------
  // sticky registers
  // ----------------------------------------
  logic [1:0] route10_q, route10_d, route11_q, route11_d;
  logic dir10_q, dir10_d, dir11_q, dir11_d;
  logic [3:0] avail_q, avail_d;
  logic [11:0] db_en_q, db_en_d, odata_q, odata_d;
  logic [11:0] mask_seen_q, mask_seen_d;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [11:0] waddr;
  logic wr_hit;
  logic [3:0] pop;

  always_comb begin
    wmask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
    // serial memory load takes the write path first; it writes whole words
    wr_hit = load_valid | (cfg_valid & cfg_write);
    waddr = load_valid ? load_addr : cfg_addr;
    wval = load_valid ? load_data : cfg_wdata;
    if (!load_valid) begin
      wval = wval & wmask;
    end
    route10_d = route10_q;
    route11_d = route11_q;
    dir10_d = dir10_q;
    dir11_d = dir11_q;
    avail_d = avail_q;
    db_en_d = db_en_q;
    odata_d = odata_q;
    mask_seen_d = assign_mask;
    pop = 4'h0;
    for (int p = 0; p < VPG_LINES; p++) begin
      pop = pop + {3'h0, assign_mask[p] & ~other_claim[p]};
    end
    if (wr_hit && (load_valid || wmask[0])) begin
      case (waddr)
        VPG_OFF_DIR_HI: begin
          route10_d = wval[VPG_L10_ROUTE_LSB +: 2];
          dir10_d = wval[VPG_L10_DIR_BIT];
          route11_d = wval[VPG_L11_ROUTE_LSB +: 2];
          dir11_d = wval[VPG_L11_DIR_BIT];
        end
        VPG_OFF_AVAIL: avail_d = wval[VPG_AVAIL_W-1:0];
        VPG_OFF_DEBOUNCE: db_en_d[7:0] = wval[7:0];
        VPG_OFF_OUT_DATA: odata_d[7:0] = wval[7:0];
        default: ;
      endcase
    end
    // byte 1 carries bits 11:8; a disabled byte keeps its bits
    if (wr_hit && (load_valid || wmask[8])) begin
      case (waddr)
        VPG_OFF_DEBOUNCE: db_en_d[11:8] = wval[11:8];
        VPG_OFF_OUT_DATA: odata_d[11:8] = wval[11:8];
        default: ;
      endcase
    end
    // a change in the assignment wins over a software write
    if (mask_seen_q != assign_mask) begin
      avail_d = (pop == 4'h0) ? 4'h0 : pop - 4'h1;
    end
  end

  always_ff @(posedge core_clk or posedge pwr_rst) begin
    if (pwr_rst) begin
      route10_q <= VPG_RST_ROUTE;
      route11_q <= VPG_RST_ROUTE;
      dir10_q <= VPG_RST_DIR;
      dir11_q <= VPG_RST_DIR;
      avail_q <= VPG_RST_AVAIL;
      db_en_q <= VPG_RST_DEBOUNCE;
      odata_q <= VPG_RST_OUT_DATA;
      mask_seen_q <= 12'h000;
    end else begin
      route10_q <= route10_d;
      route11_q <= route11_d;
      dir10_q <= dir10_d;
      dir11_q <= dir11_d;
      avail_q <= avail_d;
      db_en_q <= db_en_d;
      odata_q <= odata_d;
      mask_seen_q <= mask_seen_d;
    end
  end

  // ----------------------------------------
  // logical line view and pin mapping
  // ----------------------------------------
  logic [11:0] l_dir;
  logic [1:0] l_route [VPG_LINES];
  logic [11:0] pin_s1_q, pin_s2_q;
  logic [11:0] l_pin;
  logic [11:0] l_valid;
  logic [11:0] pin_out_d, pin_oe_d;
  logic [3:0] lcnt;
  logic [11:0] filt_q, filt_d;

  always_comb begin
    for (int l = 0; l < VPG_LO_LINES; l++) begin
      l_dir[l] = lo_dir[l];
      l_route[l] = lo_route[2*l +: 2];
    end
    l_dir[10] = dir10_q;
    l_dir[11] = dir11_q;
    l_route[10] = route10_q;
    l_route[11] = route11_q;
    l_pin = 12'h000;
    l_valid = 12'h000;
    pin_out_d = 12'h000;
    pin_oe_d = 12'h000;
    lcnt = 4'h0;
    // k-th owned physical pin backs logical line k
    for (int p = 0; p < VPG_LINES; p++) begin
      if (assign_mask[p] && !other_claim[p]) begin
        l_pin[lcnt] = pin_s2_q[p];
        l_valid[lcnt] = 1'b1;
        pin_oe_d[p] = l_dir[lcnt];
        if (l_route[lcnt] == VPG_ROUTE_IRQ) begin
          pin_out_d[p] = port_good_func[p];
        end else begin
          pin_out_d[p] = odata_q[lcnt];
        end
        lcnt = lcnt + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // de-bounce, one counter per logical line
  // ----------------------------------------
  logic [VPG_DB_CNT_W-1:0] db_cnt_q [VPG_LINES];
  logic [VPG_DB_CNT_W-1:0] db_cnt_d [VPG_LINES];
  logic [11:0] irq_src;
  logic gen_irq_d;
  logic [31:0] rdata_d;
  logic [11:0] in_data;

  always_comb begin
    for (int l = 0; l < VPG_LINES; l++) begin
      filt_d[l] = filt_q[l];
      db_cnt_d[l] = '0;
      if (!db_en_q[l] || l_dir[l]) begin
        filt_d[l] = l_pin[l];
      end else if (l_pin[l] != filt_q[l]) begin
        if (db_cnt_q[l] == VPG_DB_CNT_W'(DB_CYCLES - 1)) begin
          filt_d[l] = l_pin[l];
        end else begin
          db_cnt_d[l] = db_cnt_q[l] + 1'b1;
        end
      end
      irq_src[l] = l_valid[l] & ~l_dir[l] & (l_route[l] == VPG_ROUTE_IRQ) &
                   (filt_d[l] != filt_q[l]);
      in_data[l] = l_valid[l] & ~l_dir[l] & (l_route[l] == VPG_ROUTE_DATA) &
                   filt_q[l];
    end
    gen_irq_d = |irq_src;
    rdata_d = 32'h0000_0000;
    case (cfg_addr)
      VPG_OFF_DIR_HI: rdata_d[5:0] = {dir11_q, route11_q, dir10_q, route10_q};
      VPG_OFF_AVAIL: rdata_d[3:0] = avail_q;
      VPG_OFF_DEBOUNCE: rdata_d[11:0] = db_en_q;
      VPG_OFF_IN_DATA: rdata_d[11:0] = in_data;
      VPG_OFF_OUT_DATA: rdata_d[11:0] = odata_q;
      default: rdata_d = 32'h0000_0000;
    endcase
    if (!cfg_valid || cfg_write) begin
      rdata_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_q <= 12'h000;
      pin_s2_q <= 12'h000;
      filt_q <= 12'h000;
      for (int l = 0; l < VPG_LINES; l++) begin
        db_cnt_q[l] <= '0;
      end
      port_good_pin_out_q <= 12'h000;
      port_good_pin_oe_q <= 12'h000;
      gen_irq_q <= 1'b0;
      cfg_rdata_q <= 32'h0000_0000;
      cfg_ack_q <= 1'b0;
    end else begin
      pin_s1_q <= port_good_pin_in;
      pin_s2_q <= pin_s1_q;
      filt_q <= filt_d;
      for (int l = 0; l < VPG_LINES; l++) begin
        db_cnt_q[l] <= db_cnt_d[l];
      end
      port_good_pin_out_q <= pin_out_d;
      port_good_pin_oe_q <= pin_oe_d;
      gen_irq_q <= gen_irq_d;
      cfg_rdata_q <= rdata_d;
      cfg_ack_q <= cfg_valid;
    end
  end
endmodule

// ---- verification/vpg_port_good_chk.sv ----
`timescale 1ns/100ps
module vpg_port_good_chk
  import vpg_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic pwr_rst,
  input wire logic cfg_valid,
  input wire logic cfg_write,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_rdata_q,
  input wire logic cfg_ack_q,
  input wire logic [9:0] lo_dir,
  input wire logic [11:0] assign_mask,
  input wire logic [11:0] other_claim,
  input wire logic [11:0] port_good_pin_oe_q
);
  logic rd;
  assign rd = cfg_valid && !cfg_write;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst || pwr_rst);
  AST_ACK: assert property (cfg_valid |=> cfg_ack_q)
    else $error("no acknowledge after request");
  AST_NO_ACK: assert property (!cfg_valid |=> !cfg_ack_q)
    else $error("acknowledge without request");
  AST_IDLE: assert property (!rd |=> cfg_rdata_q == 32'h0)
    else $error("read data not zero outside a read");
  AST_DIR_RSV: assert property (rd && cfg_addr == VPG_OFF_DIR_HI
    |=> cfg_rdata_q[31:6] == 26'h0)
    else $error("direction register upper bits set");
  AST_AV_RSV: assert property (rd && cfg_addr == VPG_OFF_AVAIL
    |=> cfg_rdata_q[31:4] == 28'h0)
    else $error("availability upper bits set");
  AST_DB_RSV: assert property (rd && cfg_addr == VPG_OFF_DEBOUNCE
    |=> cfg_rdata_q[31:12] == 20'h0)
    else $error("debounce upper bits set");
  AST_IN_OUT: assert property ($stable(lo_dir)[*4] ##0 rd && cfg_addr == VPG_OFF_IN_DATA
    |=> (cfg_rdata_q[9:0] & $past(lo_dir)) == 10'h0) else $error("output line reads nonzero");
  AST_OWN: assert property ($stable(other_claim | ~assign_mask)[*3]
    |-> (port_good_pin_oe_q & (other_claim | ~assign_mask)) == 12'h0)
    else $error("pin driven that this switch does not own");
endmodule
bind vpg_port_good vpg_port_good_chk u_chk (.core_clk, .sys_rst, .pwr_rst, .cfg_valid,
  .cfg_write, .cfg_addr, .cfg_rdata_q, .cfg_ack_q, .lo_dir, .assign_mask, .other_claim,
  .port_good_pin_oe_q);

// ---- verification/vpg_pin_model.sv ----
`timescale 1ns/100ps
module vpg_pin_model (
  input wire logic [11:0] drive_oe,
  input wire logic [11:0] drive_val,
  input wire logic [11:0] ext_level,
  output logic [11:0] pin_level
);
  // board level shows only where the device has released the pin
  assign pin_level = (drive_oe & drive_val) | (~drive_oe & ext_level);
endmodule

// ---- verification/vpg_port_good_bench.sv ----
`timescale 1ns/100ps
module vpg_port_good_bench;
  import vpg_pkg::*;
  logic core_clk = 1'h0, sys_rst = 1'h1, pwr_rst = 1'h1, cfg_valid = 1'h0, cfg_write = 1'h0;
  logic load_valid = 1'h0, cfg_ack_q, gen_irq_q;
  logic [11:0] cfg_addr = '0, load_addr = '0, assign_mask = '0, other_claim = '0, ext = '0;
  logic [11:0] port_good_func = '0, port_good_pin_in, port_good_pin_out_q, port_good_pin_oe_q;
  logic [9:0] lo_dir = '0;
  logic [3:0] cfg_be = 4'hf;
  logic [31:0] cfg_wdata = '0, load_data = '0, cfg_rdata_q, rd;
  int num_errors = 0, checked = 0, n;
  vpg_port_good #(.DB_CYCLES(8)) DUT (.core_clk, .sys_rst, .pwr_rst, .cfg_valid, .cfg_write,
    .cfg_addr, .cfg_wdata, .cfg_be, .cfg_rdata_q, .cfg_ack_q, .load_valid, .load_addr,
    .load_data, .lo_dir, .lo_route(20'h00000), .assign_mask, .other_claim, .port_good_func,
    .port_good_pin_in, .port_good_pin_out_q, .port_good_pin_oe_q, .gen_irq_q);
  vpg_pin_model pins (.drive_oe(port_good_pin_oe_q), .drive_val(port_good_pin_out_q),
    .ext_level(ext), .pin_level(port_good_pin_in));
  initial forever #2.5 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cfg_valid <= 1'h1;
    cfg_write <= w;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge core_clk);
    cfg_valid <= 1'h0;
    #1;
    chk(cfg_ack_q, 32'h1);
    rd = cfg_rdata_q;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    acc(1'h0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic t_reset;
    @(posedge core_clk);
    assign_mask <= 12'h00f;
    cyc(3);
    rdc(VPG_OFF_AVAIL, '1, 32'h3);
    @(posedge core_clk);
    assign_mask <= 12'hfff;
    cyc(3);
    rdc(VPG_OFF_AVAIL, '1, 32'hb);
    rdc(VPG_OFF_DIR_HI, '1, 32'h0);
    rdc(VPG_OFF_DEBOUNCE, '1, 32'h0);
    $display("reset values done");
  endtask
  task automatic t_regs;
    acc(1'h1, VPG_OFF_DIR_HI, '1);
    rdc(VPG_OFF_DIR_HI, '1, 32'h3f);
    acc(1'h1, VPG_OFF_DEBOUNCE, '1);
    rdc(VPG_OFF_DEBOUNCE, '1, 32'hfff);
    rdc(12'ha4c, '1, 32'h0);
    acc(1'h1, VPG_OFF_DEBOUNCE, 32'h5a5);
    @(posedge core_clk);
    load_valid <= 1'h1;
    load_addr <= VPG_OFF_DIR_HI;
    load_data <= 32'hffffffed;
    @(posedge core_clk);
    load_valid <= 1'h0;
    sys_rst <= 1'h1;
    @(posedge core_clk);
    sys_rst <= 1'h0;
    rdc(VPG_OFF_DIR_HI, '1, 32'h2d);
    rdc(VPG_OFF_DEBOUNCE, '1, 32'h5a5);
    @(posedge core_clk);
    cfg_be <= 4'h1;
    acc(1'h1, VPG_OFF_DEBOUNCE, 32'h0);
    rdc(VPG_OFF_DEBOUNCE, '1, 32'h500);
    @(posedge core_clk);
    cfg_be <= 4'h2;
    acc(1'h1, VPG_OFF_DEBOUNCE, 32'hfff);
    rdc(VPG_OFF_DEBOUNCE, '1, 32'hf00);
    @(posedge core_clk);
    cfg_be <= 4'hf;
    acc(1'h1, VPG_OFF_DIR_HI, '0);
    acc(1'h1, VPG_OFF_DEBOUNCE, '0);
    $display("register access done");
  endtask
  task automatic t_out;
    @(posedge core_clk);
    ext <= 12'hc00;
    acc(1'h1, VPG_OFF_DIR_HI, 32'h4);
    acc(1'h1, VPG_OFF_OUT_DATA, 32'h400);
    cyc(2);
    chk(port_good_pin_oe_q & port_good_pin_out_q, 32'h400);
    rdc(VPG_OFF_OUT_DATA, '1, 32'h400);
    rdc(VPG_OFF_IN_DATA, 32'hc00, 32'h800);
    @(posedge core_clk);
    port_good_func <= 12'h400;
    acc(1'h1, VPG_OFF_DIR_HI, 32'h5);
    acc(1'h1, VPG_OFF_OUT_DATA, 32'h0);
    cyc(2);
    chk(port_good_pin_out_q & 12'h400, 32'h400);
    @(posedge core_clk);
    other_claim <= 12'h400;
    cyc(3);
    chk(port_good_pin_oe_q & 12'h400, 32'h0);
    @(posedge core_clk);
    other_claim <= '0;
    acc(1'h1, VPG_OFF_DIR_HI, '0);
    $display("output drive done");
  endtask
  task automatic t_in;
    @(posedge core_clk);
    ext <= 12'h001;
    cyc(4);
    rdc(VPG_OFF_IN_DATA, '1, 32'h1);
    @(posedge core_clk);
    lo_dir <= 10'h001;
    cyc(4);
    rdc(VPG_OFF_IN_DATA, '1, 32'h0);
    @(posedge core_clk);
    lo_dir <= '0;
    cyc(4);
    acc(1'h1, VPG_OFF_DEBOUNCE, 32'h1);
    @(posedge core_clk);
    ext <= '0;
    cyc(3);
    rdc(VPG_OFF_IN_DATA, '1, 32'h1);
    cyc(12);
    rdc(VPG_OFF_IN_DATA, '1, 32'h0);
    acc(1'h1, VPG_OFF_DEBOUNCE, '0);
    $display("input filter done");
  endtask
  task automatic cnt_irq;
    n = 0;
    repeat (10) begin
      @(posedge core_clk);
      #1;
      n += gen_irq_q;
    end
  endtask
  task automatic t_irq;
    acc(1'h1, VPG_OFF_DIR_HI, 32'h8);
    cyc(4);
    @(posedge core_clk);
    ext <= 12'h400;
    cnt_irq;
    chk(n, 32'h0);
    @(posedge core_clk);
    ext <= 12'hc00;
    cnt_irq;
    chk(n, 32'h1);
    rdc(VPG_OFF_IN_DATA, 32'hc00, 32'h400);
    $display("interrupt routing done");
  endtask
  task automatic test_done;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'h0;
    pwr_rst <= 1'h0;
    t_reset;
    t_regs;
    t_out;
    t_in;
    t_irq;
    test_done;
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    num_errors++;
    test_done;
  end
endmodule
